/* File: hw/fspwm_duty_gen.sv */
/*
 PWM waveform generator: phase counter advanced on each step, holds at
 full scale and restarts on the period tick. Duty maps linearly, 0 off
 and full scale always on.
 Assumes tick marks the start of each PWM period.
*/
`timescale 1ns/100ps
module fspwm_duty_gen #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Period and level
	input wire logic tick,
	input wire logic step,
	input wire logic [W-1:0] duty,
	// Waveform
	output logic pwmOn
);
	logic [W-1:0] phase;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			phase <= '0;
		end else if (tick) begin
			phase <= '0;
		end else if (step && phase != '1) begin
			phase <= phase + 1'b1;
		end
	end

	// Full scale compares always true so 100% has no gap
	assign pwmOn = (duty == '1) || (phase < duty);
endmodule

/* File: hw/fspwm_period_counter.sv */
/*
 Counts PWM period ticks; clear restarts from zero, done at the target.
 Assumes tick is a one-cycle enable at the PWM rate.
*/
`timescale 1ns/100ps
module fspwm_period_counter #(
	parameter int W = 6
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Control
	input wire logic clear,
	input wire logic tick,
	input wire logic [W-1:0] target,
	// Status
	output logic done
);
	logic [W-1:0] count;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			count <= '0;
		end else if (clear) begin
			count <= '0;
		end else if (tick && count != target) begin
			count <= count + 1'b1;
		end
	end

	assign done = (count == target);
endmodule

/* File: hw/fspwm_pkg.sv */
/*
 Package for the fan speed PWM supervisor: duty width, interval counts
 and supervisor states. Assumes one clock and a PWM period tick.
*/
package fspwm_pkg;
	// ************************************************************
	// Widths and counts
	// ************************************************************
	localparam int DUTY_W = 8;
	localparam logic [DUTY_W-1:0] DUTY_FULL = 8'hff;
	localparam logic [5:0] STARTUP_CYCLES = 6'h20;
	localparam logic [5:0] MISSING_CYCLES = 6'h20;
	localparam logic [5:0] DIAG_CYCLES = 6'h03;
	localparam logic [5:0] CNT_ZERO = 6'h00;

	// ************************************************************
	// Supervisor states
	// ************************************************************
	typedef enum logic [2:0] {
		ST_SHUTDOWN = 3'b000,
		ST_AUTO_OFF = 3'b001,
		ST_START1 = 3'b010,
		ST_START2 = 3'b011,
		ST_NORMAL = 3'b100,
		ST_DIAG = 3'b101,
		ST_RETRY = 3'b110,
		ST_FAULT = 3'b111
	} fspwm_state_e;
endpackage

/* File: hw/fspwm_supervisor.sv */
/*
 Fan speed PWM supervisor: duty drive, start-up and retry timing,
 missing-pulse detection, fault and over-temperature flag.
 Assumes comparator levels and tach pulses synchronous to ref_clk and a
 one-cycle pwmTick per PWM period from the ramp comparator.
*/
`timescale 1ns/100ps
module fspwm_supervisor #(
	parameter int DUTY_W = fspwm_pkg::DUTY_W
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// PWM time base
	input wire logic pwmTick,
	input wire logic pwmStep,
	// Control level and comparator results
	input wire logic [DUTY_W-1:0] tempControlInput,
	input wire logic belowShutdownLevel,
	input wire logic aboveReleaseLevel,
	input wire logic belowAutoOffThreshold,
	input wire logic aboveAutoOffHysteresis,
	input wire logic aboveFullDutyOvertempLevel,
	// Fan tachometer
	input wire logic tachPulse,
	// Outputs
	output logic fanDriveOutput,
	output logic faultN
);
	import fspwm_pkg::*;

	// ************************************************************
	// State
	// ************************************************************
	fspwm_state_e state;
	fspwm_state_e next_state;
	logic pwmOn;
	logic pwmOnDly;
	logic tachSeen;
	logic qualPulse;
	logic intervalDone;
	logic missDone;
	logic intervalClear;
	logic missClear;
	logic [5:0] intervalTarget;
	logic [DUTY_W-1:0] duty;
	logic driveOn;
	logic fullOn;

	function automatic logic is_running(input fspwm_state_e s);
		is_running = (s != ST_SHUTDOWN) && (s != ST_AUTO_OFF) &&
			(s != ST_FAULT);
	endfunction

	// ************************************************************
	// Duty and waveform
	// ************************************************************
	// Comparator at full duty overrides the level so warning and 100%
	// agree even if the analog span saturates early
	assign duty = aboveFullDutyOvertempLevel ? DUTY_FULL :
		tempControlInput;

	fspwm_duty_gen #(
		.W(DUTY_W)
	) u_duty (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.tick(pwmTick),
		.step(pwmStep),
		.duty(duty),
		.pwmOn(pwmOn)
	);

	// ************************************************************
	// Tach blanking and pulse capture
	// ************************************************************
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pwmOnDly <= 1'b0;
		end else begin
			pwmOnDly <= fanDriveOutput;
		end
	end

	// Pulses on the pin's rising edge are switching noise, not rotation;
	// blanking follows the registered pin, not the internal request
	assign qualPulse = tachPulse && !(fanDriveOutput && !pwmOnDly);

	// Sticky per interval; a pulse on the clearing cycle still counts
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			tachSeen <= 1'b0;
		end else if (qualPulse) begin
			tachSeen <= 1'b1;
		end else if (intervalClear) begin
			tachSeen <= 1'b0;
		end
	end

	// ************************************************************
	// Interval timers in PWM cycles
	// ************************************************************
	assign intervalTarget = (state == ST_DIAG) ? DIAG_CYCLES :
		STARTUP_CYCLES;
	assign intervalClear = (next_state != state);
	assign missClear = (state != ST_NORMAL) || qualPulse
		|| intervalClear;

	fspwm_period_counter #(
		.W(6)
	) u_interval (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.clear(intervalClear),
		.tick(pwmTick),
		.target(intervalTarget),
		.done(intervalDone)
	);

	fspwm_period_counter #(
		.W(6)
	) u_missing (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.clear(missClear),
		.tick(pwmTick),
		.target(MISSING_CYCLES),
		.done(missDone)
	);

	// ************************************************************
	// Supervisor sequence
	// ************************************************************
	always_comb begin
		next_state = state;
		case (state)
			ST_SHUTDOWN: begin
				if (aboveReleaseLevel && !belowShutdownLevel) begin
					next_state = aboveAutoOffHysteresis ? ST_START1 :
						ST_AUTO_OFF;
				end
			end
			ST_AUTO_OFF: begin
				if (aboveAutoOffHysteresis) begin
					next_state = ST_START1;
				end
			end
			ST_START1: begin
				if (tachSeen && intervalDone) begin
					next_state = ST_NORMAL;
				end else if (intervalDone) begin
					next_state = ST_START2;
				end
			end
			ST_START2: begin
				if (tachSeen && intervalDone) begin
					next_state = ST_NORMAL;
				end else if (intervalDone) begin
					next_state = ST_FAULT;
				end
			end
			ST_NORMAL: begin
				if (missDone) begin
					next_state = ST_DIAG;
				end
			end
			ST_DIAG: begin
				if (tachSeen) begin
					next_state = ST_NORMAL;
				end else if (intervalDone) begin
					next_state = ST_RETRY;
				end
			end
			ST_RETRY: begin
				if (tachSeen && intervalDone) begin
					next_state = ST_NORMAL;
				end else if (intervalDone) begin
					next_state = ST_FAULT;
				end
			end
			ST_FAULT: begin
				next_state = ST_FAULT;
			end
			default: begin
				next_state = ST_SHUTDOWN;
			end
		endcase
		// Shutdown wins over all, including a latched fault
		if (belowShutdownLevel) begin
			next_state = ST_SHUTDOWN;
		end else if (belowAutoOffThreshold && is_running(state)) begin
			next_state = ST_AUTO_OFF;
		end
	end

	// Power-up behaves as a release from shutdown
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state <= ST_SHUTDOWN;
		end else begin
			state <= next_state;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign fullOn = (state == ST_START1) || (state == ST_START2) ||
		(state == ST_DIAG) || (state == ST_RETRY);
	assign driveOn = is_running(state) && (fullOn || pwmOn);

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			fanDriveOutput <= 1'b0;
		end else begin
			fanDriveOutput <= driveOn;
		end
	end

	// Fault pin active low; unlatched full-duty warning only while running
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			faultN <= 1'b1;
		end else if (next_state == ST_FAULT) begin
			faultN <= 1'b0;
		end else if (!is_running(next_state)) begin
			faultN <= 1'b1;
		end else begin
			faultN <= !(duty == DUTY_FULL);
		end
	end
endmodule

/* File: verification/fan_speed_pwm_supervisor_bench.sv */
/*
 Self-checking bench for fspwm_supervisor with a fan model.
 Assumes a 256-clock PWM period and ports as declared.
*/
`timescale 1ns/100ps
module fan_speed_pwm_supervisor_bench;
	import fspwm_pkg::*;
	// ****************************************
	// Stimulus and checks
	// ****************************************
	logic ref_clk = 0, rstn = 0, pwmTick = 0, pwmStep = 0;
	logic [7:0] tempControlInput = 8'h00, ph = 8'h00;
	logic belowShutdownLevel = 1, aboveReleaseLevel = 0;
	logic belowAutoOffThreshold = 0, aboveAutoOffHysteresis = 1;
	logic aboveFullDutyOvertempLevel = 0;
	logic [1:0] fanMode = 2'h0;
	logic tachPulse, fanDriveOutput, faultN;
	int fails = 0, num_checks = 0, seed = 45, n, d;
	always #2 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		ph <= ph + 8'h01;
		pwmTick <= ph == 8'hff;
		pwmStep <= 1'b1;
	end
	fspwm_supervisor DUT (.ref_clk(ref_clk), .rstn(rstn),
		.pwmTick(pwmTick), .pwmStep(pwmStep),
		.tempControlInput(tempControlInput),
		.belowShutdownLevel(belowShutdownLevel),
		.aboveReleaseLevel(aboveReleaseLevel),
		.belowAutoOffThreshold(belowAutoOffThreshold),
		.aboveAutoOffHysteresis(aboveAutoOffHysteresis),
		.aboveFullDutyOvertempLevel(aboveFullDutyOvertempLevel),
		.tachPulse(tachPulse), .fanDriveOutput(fanDriveOutput),
		.faultN(faultN));
	fspwm_fan_model fan (.ref_clk(ref_clk),
		.fanDriveOutput(fanDriveOutput), .fanMode(fanMode),
		.tachPulse(tachPulse));
	task automatic chk(input logic [8:0] got, input int e, tol = 0);
		num_checks++;
		if (tol == 0 ? got !== 9'(e) : got + tol < e || got > e + tol) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, e);
		end
	endtask
	task automatic lv(input logic sd, rl, ao, hy, ov,
		input logic [7:0] t, input logic [1:0] fm);
		@(posedge ref_clk);
		belowShutdownLevel <= sd;
		aboveReleaseLevel <= rl;
		belowAutoOffThreshold <= ao;
		aboveAutoOffHysteresis <= hy;
		aboveFullDutyOvertempLevel <= ov;
		tempControlInput <= t;
		fanMode <= fm;
	endtask
	// Bounded wait for a fan fault, counted in PWM periods
	task automatic waitf(input int e, tol);
		int t;
		for (t = 0; t < e + 4 && faultN !== 1'b0; t++) @(posedge pwmTick);
		if (t == e + 4) begin
			fails++;
			tally_and_finish;
		end else chk(t, e, tol);
	endtask
	task automatic duty(output int c);
		@(posedge pwmTick);
		c = 0;
		repeat (256) begin
			@(posedge ref_clk);
			#1 c += fanDriveOutput;
		end
	endtask
	task automatic tally_and_finish;
		if (fails == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		#1 chk(faultN, 1);
		chk(fanDriveOutput, 0);
		lv(0, 1, 0, 1, 0, 8'h40, 2);
		repeat (8) @(posedge ref_clk);
		#1 chk(fanDriveOutput, 1);
		waitf(65, 1);
		repeat (4) @(posedge ref_clk);
		#1 chk(fanDriveOutput, 0);
		lv(1, 0, 0, 1, 0, 8'h40, 0);
		repeat (8) @(posedge ref_clk);
		#1 chk(faultN, 1);
		lv(0, 1, 0, 1, 0, 8'h40, 0);
		repeat (34) @(posedge pwmTick);
		for (int i = 0; i < 3; i++) begin
			d = 32 + ($random(seed) & 127);
			lv(0, 1, 0, 1, 0, d[7:0], 0);
			repeat (2) @(posedge pwmTick);
			duty(n);
			chk(n, d, 2);
		end
		lv(0, 1, 0, 1, 1, 8'h40, 0);
		duty(n);
		chk(n, 256);
		chk(faultN, 0);
		lv(0, 1, 0, 1, 0, 8'h40, 0);
		repeat (4) @(posedge ref_clk);
		#1 chk(faultN, 1);
		lv(0, 1, 0, 1, 0, 8'h40, 1);
		waitf(68, 2);
		lv(1, 0, 0, 1, 0, 8'h40, 1);
		repeat (3) @(posedge ref_clk);
		lv(0, 1, 1, 0, 0, 8'h40, 1);
		repeat (40) @(posedge pwmTick);
		#1 chk(faultN, 1);
		chk(fanDriveOutput, 0);
		lv(0, 1, 0, 1, 0, 8'h40, 0);
		repeat (31) @(posedge pwmTick);
		#1 chk(fanDriveOutput, 1);
		tally_and_finish;
	end
endmodule

/* File: verification/fspwm_fan_model.sv */
/*
 Fan and sense network: tach pulses only while current flows.
 Assumes mode from the bench: 0 spins, 1 stalled, 2 turn-on spikes.
*/
`timescale 1ns/100ps
module fspwm_fan_model (
	// Clock and drive
	input wire logic ref_clk,
	input wire logic fanDriveOutput,
	input wire logic [1:0] fanMode,
	// Sense
	output logic tachPulse
);
	// ****************************************
	// Commutation
	// ****************************************
	logic [3:0] cnt = 4'h0;
	logic prev = 1'b0;
	always_ff @(posedge ref_clk) begin
		cnt <= cnt + 4'h1;
		prev <= fanDriveOutput;
	end
	// Mode 2 only gives the spike of switch-on, which must not count
	assign tachPulse = fanMode == 2'h0 ? fanDriveOutput && cnt == 4'h0 :
		fanMode == 2'h2 && fanDriveOutput && !prev;
endmodule

/* File: verification/fspwm_supervisor_properties.sv */
/*
 Port checker for fspwm_supervisor, bound below.
 Assumes the bench keeps comparator levels consistent.
*/
`timescale 1ns/100ps
module fspwm_supervisor_properties #(
	parameter int DUTY_W = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Inputs
	input wire logic pwmTick,
	input wire logic pwmStep,
	input wire logic [DUTY_W-1:0] tempControlInput,
	input wire logic belowShutdownLevel,
	input wire logic aboveReleaseLevel,
	input wire logic belowAutoOffThreshold,
	input wire logic aboveAutoOffHysteresis,
	input wire logic aboveFullDutyOvertempLevel,
	input wire logic tachPulse,
	// Outputs
	input wire logic fanDriveOutput,
	input wire logic faultN
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// Ticks of a dark fan while supervision is live
	logic [6:0] idleTicks;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			idleTicks <= 7'h00;
		end else if (fanDriveOutput || !faultN || belowShutdownLevel ||
			belowAutoOffThreshold || !aboveAutoOffHysteresis) begin
			idleTicks <= 7'h00;
		end else if (pwmTick) begin
			idleTicks <= idleTicks + 7'h01;
		end
	end
	shutdown_quiet_a: assert property (
		belowShutdownLevel[*4] |-> faultN && !fanDriveOutput)
		else $error("drive or fault active in shutdown");
	auto_quiet_a: assert property (
		(faultN && belowAutoOffThreshold && !belowShutdownLevel &&
		!aboveFullDutyOvertempLevel)[*4] |-> !fanDriveOutput)
		else $error("fan driven in auto-off");
	fault_off_a: assert property (
		(!faultN && !aboveFullDutyOvertempLevel)[*4] |-> !fanDriveOutput)
		else $error("fan driven while fault latched");
	fault_latch_a: assert property (
		(!faultN && !aboveFullDutyOvertempLevel &&
		!belowShutdownLevel)[*4] |=> !faultN)
		else $error("fan fault released without shutdown");
	start_drive_a: assert property (
		belowShutdownLevel ##1 (!belowShutdownLevel && aboveReleaseLevel
		&& aboveAutoOffHysteresis && !belowAutoOffThreshold)[*6]
		|-> fanDriveOutput)
		else $error("no full drive after start");
	idle_bound_a: assert property (
		idleTicks <= 7'h22)
		else $error("missing pulse timeout not taken");
	overtemp_flag_a: assert property (
		(aboveFullDutyOvertempLevel && fanDriveOutput &&
		!belowShutdownLevel)[*4] |-> !faultN)
		else $error("full duty not flagged");
	overtemp_release_a: assert property (
		$rose(faultN) |-> !$past(aboveFullDutyOvertempLevel) ||
		$past(belowShutdownLevel) || $past(belowShutdownLevel, 2))
		else $error("fault released while at full duty");
	cover property ($fell(faultN) && !aboveFullDutyOvertempLevel);
	cover property ($fell(belowShutdownLevel));
	cover property (idleTicks == 7'h20);
endmodule
bind fspwm_supervisor fspwm_supervisor_properties #(
	.DUTY_W(DUTY_W)
) chkInst (
	.ref_clk(ref_clk), .rstn(rstn), .pwmTick(pwmTick),
	.pwmStep(pwmStep), .tempControlInput(tempControlInput),
	.belowShutdownLevel(belowShutdownLevel),
	.aboveReleaseLevel(aboveReleaseLevel),
	.belowAutoOffThreshold(belowAutoOffThreshold),
	.aboveAutoOffHysteresis(aboveAutoOffHysteresis),
	.aboveFullDutyOvertempLevel(aboveFullDutyOvertempLevel),
	.tachPulse(tachPulse), .fanDriveOutput(fanDriveOutput),
	.faultN(faultN)
);
